/* File: hw/pad_hysteresis_and_disable_regs.sv */
/*
 pad_hysteresis_and_disable_regs: pad hysteresis selectors for port 0
 pins 8..15, port 1 pins 0..6 and port 2 pins 8..11, and read-only pad
 disable status words for ports 0 and 1, behind a classic Wishbone
 slave.
 assumes a single clock, synchronous reset, and a master that holds its
 request until ack.
*/
// Operation
// - port1 low selectors at bits 2..26
// - port0 high selectors, every fourth bit 2..30
// - port2 high selectors bits 2..14, rest reserved
// - hysteresis registers reset to zero
// - reserved bits read zero, writes ignored
// - port0/port1 pad status read-only, package pins
// - port0 status pins 0..15, one means disabled
// - port1 status pins 0..6, upper bits zero
// - status low half from parameter, upper zero
// - selector zero standard, one large hysteresis
// - hysteresis independent of pin control words
`timescale 1ns/1ps
`default_nettype none

module pad_hysteresis_and_disable_regs #(
   parameter logic [15:0] PORT0_PAD_DISABLE = 16'h0000,
   parameter logic [15:0] PORT1_PAD_DISABLE = 16'h0000
) (
   input  wire logic                          clk_i,     // 200 MHz clock
   input  wire logic                          rst_i,     // sync reset, high
   input  wire logic [pad_cfg_pkg::ADDR_W-1:0] wb_adr_i, // byte address
   input  wire logic [pad_cfg_pkg::DATA_W-1:0] wb_dat_i, // write data
   input  wire logic [pad_cfg_pkg::SEL_W-1:0]  wb_sel_i, // byte lanes
   input  wire logic                          wb_we_i,   // write
   input  wire logic                          wb_cyc_i,  // cycle
   input  wire logic                          wb_stb_i,  // strobe
   output logic      [pad_cfg_pkg::DATA_W-1:0] wb_dat_o, // read data
   output logic                               wb_ack_o,  // acknowledge
   output logic [pad_cfg_pkg::PORT0_HIGH_PINS-1:0]
                                     port0_hysteresis_select_o, // p0.8..15
   output logic [pad_cfg_pkg::PORT1_LOW_PINS-1:0]
                                     port1_hysteresis_select_o, // p1.0..6
   output logic [pad_cfg_pkg::PORT2_HIGH_PINS-1:0]
                                     port2_hysteresis_select_o, // p2.8..11
   output logic [pad_cfg_pkg::PORT0_PAD_PINS-1:0]
                                     port0_pad_off_flag_o,      // p0 pads
   output logic [pad_cfg_pkg::PORT1_PAD_PINS-1:0]
                                     port1_pad_off_flag_o       // p1 pads
);
   import pad_cfg_pkg::*;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   generate
      if (PORT1_PAD_DISABLE[15:PORT1_PAD_PINS] != '0) begin : g_bad_p1
         $error("port 1 has only pins 0 to 6");
      end
   endgenerate

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic adr_hit(input logic [ADDR_W-1:0] adr,
                                    input logic [ADDR_W-1:0] target);
      adr_hit = (adr[ADDR_W-1:2] == target[ADDR_W-1:2]);
   endfunction

   logic        ack_reg;
   logic        ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   wire         req_new;
   wire         wr_new;
   wire         hit_p1_low;
   wire         hit_p0_high;
   wire         hit_p2_high;
   wire         hit_p0_pad;
   wire         hit_p1_pad;
   wire         we_p1_low;
   wire         we_p0_high;
   wire         we_p2_high;

   assign req_new     = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_new      = req_new & wb_we_i;
   assign hit_p1_low  = adr_hit(wb_adr_i, PORT1_HYSTERESIS_LOW_ADR);
   assign hit_p0_high = adr_hit(wb_adr_i, PORT0_HYSTERESIS_HIGH_ADR);
   assign hit_p2_high = adr_hit(wb_adr_i, PORT2_HYSTERESIS_HIGH_ADR);
   assign hit_p0_pad  = adr_hit(wb_adr_i, PORT0_PAD_DISABLE_STATUS_ADR);
   assign hit_p1_pad  = adr_hit(wb_adr_i, PORT1_PAD_DISABLE_STATUS_ADR);
   assign we_p1_low   = wr_new & hit_p1_low;
   assign we_p0_high  = wr_new & hit_p0_high;
   assign we_p2_high  = wr_new & hit_p2_high;

   // ---------------------------------------------------------------
   // hysteresis control words, kept apart from any pin control word
   // ---------------------------------------------------------------
   logic [31:0] p1_low_q;
   logic [31:0] p0_high_q;
   logic [31:0] p2_high_q;

   masked_word_reg #(
      .WRITE_MASK  (PORT1_HYST_LOW_MASK),
      .RESET_VALUE (HYST_RESET)
   ) u_p1_low (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (we_p1_low),
      .sel_i   (wb_sel_i),
      .wdata_i (wb_dat_i),
      .q_o     (p1_low_q)
   );

   masked_word_reg #(
      .WRITE_MASK  (PORT0_HYST_HIGH_MASK),
      .RESET_VALUE (HYST_RESET)
   ) u_p0_high (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (we_p0_high),
      .sel_i   (wb_sel_i),
      .wdata_i (wb_dat_i),
      .q_o     (p0_high_q)
   );

   masked_word_reg #(
      .WRITE_MASK  (PORT2_HYST_HIGH_MASK),
      .RESET_VALUE (HYST_RESET)
   ) u_p2_high (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (we_p2_high),
      .sel_i   (wb_sel_i),
      .wdata_i (wb_dat_i),
      .q_o     (p2_high_q)
   );

   // ---------------------------------------------------------------
   // selector fan-out, 0 standard, 1 large hysteresis
   // ---------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < PORT0_HIGH_PINS; k++) begin : g_p0
         assign port0_hysteresis_select_o[k] =
            p0_high_q[HYST_FIRST_BIT + HYST_STRIDE*k];
      end
      for (k = 0; k < PORT1_LOW_PINS; k++) begin : g_p1
         assign port1_hysteresis_select_o[k] =
            p1_low_q[HYST_FIRST_BIT + HYST_STRIDE*k];
      end
      for (k = 0; k < PORT2_HIGH_PINS; k++) begin : g_p2
         assign port2_hysteresis_select_o[k] =
            p2_high_q[HYST_FIRST_BIT + HYST_STRIDE*k];
      end
   endgenerate

   // ---------------------------------------------------------------
   // pad disable status, fixed by the package
   // ---------------------------------------------------------------
   logic [31:0] p0_pad_reg;
   logic [31:0] p1_pad_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p0_pad_reg <= {PAD_UPPER_RESET, PORT0_PAD_DISABLE};
         p1_pad_reg <= {PAD_UPPER_RESET, PORT1_PAD_DISABLE} &
                       PORT1_PAD_MASK;
      end else begin
         p0_pad_reg <= p0_pad_reg & PORT0_PAD_MASK;
         p1_pad_reg <= p1_pad_reg & PORT1_PAD_MASK;
      end
   end

   assign port0_pad_off_flag_o = p0_pad_reg[PORT0_PAD_PINS-1:0];
   assign port1_pad_off_flag_o = p1_pad_reg[PORT1_PAD_PINS-1:0];

   // ---------------------------------------------------------------
   // read mux and one-wait-state acknowledge
   // ---------------------------------------------------------------
   wire [31:0] rd_mux;

   assign rd_mux = hit_p1_low  ? p1_low_q   :
                   hit_p0_high ? p0_high_q  :
                   hit_p2_high ? p2_high_q  :
                   hit_p0_pad  ? p0_pad_reg :
                   hit_p1_pad  ? p1_pad_reg :
                   UNMAPPED_READ;

   assign ack_next   = req_new;
   assign rdata_next = (req_new & ~wb_we_i) ? rd_mux : rdata_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_ACK_TIMING: assert property (@(posedge clk_i) disable iff (rst_i)
      req_new |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");

   AST_RESET_ZERO: assert property (@(posedge clk_i)
      $fell(rst_i) |-> (p1_low_q == 32'h00000000) &&
         (p0_high_q == 32'h00000000) &&
         (p2_high_q == 32'h00000000))
      else $error("hysteresis word not zero after reset");

   AST_P1_LOW_LAYOUT: assert property (@(posedge clk_i) disable iff (rst_i)
      (p1_low_q & ~32'h04444444) == 32'h00000000)
      else $error("port1 low word has bits off the selector grid");

   AST_P0_HIGH_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (we_p0_high && wb_sel_i == 4'hF) |=>
         p0_high_q == ($past(wb_dat_i) & 32'h44444444))
      else $error("port0 high word did not take the write");

   AST_P2_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      p2_high_q[31:15] == 17'h00000)
      else $error("port2 high word upper bits set");

   AST_P0_PAD_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(!rst_i) |-> $stable(p0_pad_reg))
      else $error("port0 pad status changed");

   AST_P0_PAD_VALUE: assert property (@(posedge clk_i) disable iff (rst_i)
      p0_pad_reg == {16'h0000, PORT0_PAD_DISABLE})
      else $error("port0 pad status differs from package value");

   AST_P1_PAD_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_new && !wb_we_i && hit_p1_pad) |=>
         wb_dat_o[31:7] == 25'h0000000)
      else $error("port1 pad status upper bits read nonzero");

   AST_SELECT_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
      (we_p1_low && wb_sel_i[0]) |=>
         port1_hysteresis_select_o[0] == $past(wb_dat_i[2]))
      else $error("pin 0 selector not taken from bit 2");

   AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_new && !wb_we_i && !(hit_p1_low || hit_p0_high || hit_p2_high ||
         hit_p0_pad || hit_p1_pad)) |=> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");

endmodule

`default_nettype wire

/* File: pkg/pad_cfg_pkg.sv */
/*
 pad_cfg_pkg: register map, field layout and reset values of the pad
 hysteresis and pad-disable status registers.
 assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package pad_cfg_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SEL_W  = 4;

   // ---------------------------------------------------------------
   // register byte addresses (port base plus in-port offset)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PORT0_BASE               = 10'h000;
   localparam logic [ADDR_W-1:0] PORT1_BASE               = 10'h100;
   localparam logic [ADDR_W-1:0] PORT2_BASE               = 10'h200;
   localparam logic [ADDR_W-1:0] HYST_LOW_OFS             = 10'h040;
   localparam logic [ADDR_W-1:0] HYST_HIGH_OFS            = 10'h044;
   localparam logic [ADDR_W-1:0] PAD_STATUS_OFS           = 10'h060;
   localparam logic [ADDR_W-1:0] PORT1_HYSTERESIS_LOW_ADR =
      PORT1_BASE | HYST_LOW_OFS;
   localparam logic [ADDR_W-1:0] PORT0_HYSTERESIS_HIGH_ADR =
      PORT0_BASE | HYST_HIGH_OFS;
   localparam logic [ADDR_W-1:0] PORT2_HYSTERESIS_HIGH_ADR =
      PORT2_BASE | HYST_HIGH_OFS;
   localparam logic [ADDR_W-1:0] PORT0_PAD_DISABLE_STATUS_ADR =
      PORT0_BASE | PAD_STATUS_OFS;
   localparam logic [ADDR_W-1:0] PORT1_PAD_DISABLE_STATUS_ADR =
      PORT1_BASE | PAD_STATUS_OFS;

   // ---------------------------------------------------------------
   // field layout: one selector every fourth bit from bit 2
   // ---------------------------------------------------------------
   localparam int unsigned HYST_FIRST_BIT   = 2;
   localparam int unsigned HYST_STRIDE      = 4;
   localparam int unsigned PORT1_LOW_PINS   = 7;
   localparam int unsigned PORT0_HIGH_PINS  = 8;
   localparam int unsigned PORT2_HIGH_PINS  = 4;
   localparam int unsigned PORT0_PAD_PINS   = 16;
   localparam int unsigned PORT1_PAD_PINS   = 7;
   localparam logic [DATA_W-1:0] PORT1_HYST_LOW_MASK  = 32'h04444444;
   localparam logic [DATA_W-1:0] PORT0_HYST_HIGH_MASK = 32'h44444444;
   localparam logic [DATA_W-1:0] PORT2_HYST_HIGH_MASK = 32'h00004444;
   localparam logic [DATA_W-1:0] PORT0_PAD_MASK       = 32'h0000FFFF;
   localparam logic [DATA_W-1:0] PORT1_PAD_MASK       = 32'h0000007F;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] HYST_RESET     = 32'h00000000;
   localparam logic [15:0]       PAD_UPPER_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] UNMAPPED_READ  = 32'h00000000;

   // ---------------------------------------------------------------
   // hysteresis coding
   // ---------------------------------------------------------------
   typedef enum logic {
      HYST_STANDARD = 1'b0,
      HYST_LARGE    = 1'b1
   } hysteresis_t;

endpackage

/* File: hw/masked_word_reg.sv */
/*
 masked_word_reg: one 32-bit register in which only the bits set in
 WRITE_MASK are storage; all others read as zero.
 assumes write strobe and byte lanes come from the bus slave on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module masked_word_reg #(
   parameter logic [31:0] WRITE_MASK  = 32'h00000000,
   parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
   input  wire logic        clk_i,    // system clock
   input  wire logic        rst_i,    // synchronous reset, high
   input  wire logic        we_i,     // write strobe, one cycle
   input  wire logic [3:0]  sel_i,    // byte lanes
   input  wire logic [31:0] wdata_i,  // write data
   output logic      [31:0] q_o       // stored word
);
   logic [31:0] word_reg;
   logic [31:0] word_next;
   logic [31:0] lane_mask;

   // ---------------------------------------------------------------
   // byte lanes gated by the storage mask
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{sel_i[g]}} & WRITE_MASK[g*8 +: 8];
      end
   endgenerate

   assign word_next = we_i ?
      ((word_reg & ~lane_mask) | (wdata_i & lane_mask)) : word_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_reg <= RESET_VALUE & WRITE_MASK;
      end else begin
         word_reg <= word_next & WRITE_MASK;
      end
   end

   assign q_o = word_reg;

   AST_MASKED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      (word_reg & ~WRITE_MASK) == 32'h00000000)
      else $error("reserved bit holds a one");

endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
/*
 tb_top: self-checking testbench for pad_hysteresis_and_disable_regs.
 assumes the package pad_cfg_pkg, a 200 MHz clock and a design that
 answers each classic Wishbone request with a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import pad_cfg_pkg::*;

   // ---------------------------------------------------------------
   // signals and design
   // ---------------------------------------------------------------
   localparam logic [15:0] P0_PADS = 16'hA5C3;
   localparam logic [15:0] P1_PADS = 16'h0055;

   logic              clk_i;
   logic              rst_i;
   logic [ADDR_W-1:0] wb_adr_i;
   logic [DATA_W-1:0] wb_dat_i;
   logic [SEL_W-1:0]  wb_sel_i;
   logic              wb_we_i;
   logic              wb_cyc_i;
   logic              wb_stb_i;
   logic [DATA_W-1:0] wb_dat_o;
   logic              wb_ack_o;
   logic [7:0]        p0_sel;
   logic [6:0]        p1_sel;
   logic [3:0]        p2_sel;
   logic [15:0]       p0_off;
   logic [6:0]        p1_off;
   int                fail_count;
   int                total_checks;
   logic [31:0]       rd;
   logic [ADDR_W-1:0] adr_tab [3];
   logic [31:0]       mask_tab [3];
   int                pins_tab [3];

   pad_hysteresis_and_disable_regs #(
      .PORT0_PAD_DISABLE(P0_PADS),
      .PORT1_PAD_DISABLE(P1_PADS)
   ) dut (
      .clk_i                     (clk_i),
      .rst_i                     (rst_i),
      .wb_adr_i                  (wb_adr_i),
      .wb_dat_i                  (wb_dat_i),
      .wb_sel_i                  (wb_sel_i),
      .wb_we_i                   (wb_we_i),
      .wb_cyc_i                  (wb_cyc_i),
      .wb_stb_i                  (wb_stb_i),
      .wb_dat_o                  (wb_dat_o),
      .wb_ack_o                  (wb_ack_o),
      .port0_hysteresis_select_o (p0_sel),
      .port1_hysteresis_select_o (p1_sel),
      .port2_hysteresis_select_o (p2_sel),
      .port0_pad_off_flag_o      (p0_off),
      .port1_pad_off_flag_o      (p1_off)
   );

   always #2.5 clk_i = ~clk_i;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s: got %h want %h", $time, msg, seen,
                  exp);
      end
   endtask

   // one classic cycle; ack and read data are taken at one rising edge,
   // the request is released right after it; the watchdog ends a hang
   task automatic wb_access(input logic [ADDR_W-1:0] adr,
                            input logic we, input logic [31:0] dat,
                            input logic [3:0] sel, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= adr;
      wb_we_i  <= we;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      check(n, 32'h2, "ack latency");
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
      check({31'h0, wb_ack_o}, 32'h0, "ack longer than one cycle");
   endtask

   task automatic wr(input logic [ADDR_W-1:0] adr, input logic [31:0] d,
                     input logic [3:0] sel);
      logic [31:0] q;
      wb_access(adr, 1'b1, d, sel, q);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] adr,
                         input logic [31:0] exp, input string msg);
      logic [31:0] q;
      wb_access(adr, 1'b0, 32'h00000000, 4'hF, q);
      check(q, exp, msg);
   endtask

   function automatic logic [31:0] hyst_out(input int i);
      case (i)
         0: hyst_out = {25'h0, p1_sel};
         1: hyst_out = {24'h0, p0_sel};
         default: hyst_out = {28'h0, p2_sel};
      endcase
   endfunction

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      wb_adr_i = '0;
      wb_dat_i = '0;
      wb_sel_i = '0;
      wb_we_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      fail_count = 0;
      total_checks = 0;
      adr_tab = '{PORT1_HYSTERESIS_LOW_ADR, PORT0_HYSTERESIS_HIGH_ADR,
                  PORT2_HYSTERESIS_HIGH_ADR};
      mask_tab = '{32'h04444444, 32'h44444444, 32'h00004444};
      pins_tab = '{7, 8, 4};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values and pad status words
      for (int i = 0; i < 3; i++) begin
         rd_chk(adr_tab[i], 32'h00000000, "hyst reset");
         check(hyst_out(i), 32'h0, "hyst out reset");
      end
      rd_chk(PORT0_PAD_DISABLE_STATUS_ADR, {16'h0, P0_PADS}, "p0 pad");
      rd_chk(PORT1_PAD_DISABLE_STATUS_ADR, {25'h0, P1_PADS[6:0]},
             "p1 pad");
      check({16'h0, p0_off}, {16'h0, P0_PADS}, "p0 flags");
      check({25'h0, p1_off}, {25'h0, P1_PADS[6:0]}, "p1 flags");
      // all ones: only selectors stick, reserved bits read zero
      for (int i = 0; i < 3; i++) begin
         wr(adr_tab[i], 32'hFFFFFFFF, 4'hF);
         rd_chk(adr_tab[i], mask_tab[i], "ones readback");
         check(hyst_out(i), (32'h1 << pins_tab[i]) - 1, "ones out");
      end
      // byte lanes: only the enabled lane is written
      wr(PORT0_HYSTERESIS_HIGH_ADR, 32'h00000000, 4'h1);
      rd_chk(PORT0_HYSTERESIS_HIGH_ADR, 32'h44444400, "lane 0");
      check(hyst_out(1), 32'h000000FC, "lane 0 out");
      wr(PORT1_HYSTERESIS_LOW_ADR, 32'h00000000, 4'h8);
      rd_chk(PORT1_HYSTERESIS_LOW_ADR, 32'h00444444, "lane 3");
      check(hyst_out(0), 32'h0000003F, "lane 3 out");
      // walking selector: each bit drives exactly its own pad
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < pins_tab[i]; k++) begin
            wr(adr_tab[i], 32'h1 << (2 + 4 * k), 4'hF);
            rd_chk(adr_tab[i], 32'h1 << (2 + 4 * k), "walk read");
            check(hyst_out(i), 32'h1 << k, "walk out");
         end
         wr(adr_tab[i], 32'h00000000, 4'hF);
         check(hyst_out(i), 32'h0, "clear out");
      end
      // writes to read-only status and unmapped places are ignored
      wr(PORT0_PAD_DISABLE_STATUS_ADR, 32'hFFFFFFFF, 4'hF);
      wr(PORT1_PAD_DISABLE_STATUS_ADR, 32'hFFFFFFFF, 4'hF);
      rd_chk(PORT0_PAD_DISABLE_STATUS_ADR, {16'h0, P0_PADS}, "p0 ro");
      rd_chk(PORT1_PAD_DISABLE_STATUS_ADR, {25'h0, P1_PADS[6:0]},
             "p1 ro");
      check({16'h0, p0_off}, {16'h0, P0_PADS}, "p0 flags ro");
      wr(10'h040, 32'hFFFFFFFF, 4'hF);
      rd_chk(10'h040, 32'h00000000, "unmapped read");
      rd_chk(10'h3FC, 32'h00000000, "unmapped top");
      for (int i = 0; i < 3; i++)
         check(hyst_out(i), 32'h0, "unmapped write leak");
      // reset in mid-run clears selectors again
      wr(PORT0_HYSTERESIS_HIGH_ADR, 32'hFFFFFFFF, 4'hF);
      do_reset();
      @(negedge clk_i);
      check(hyst_out(1), 32'h0, "mid reset out");
      rd_chk(PORT0_HYSTERESIS_HIGH_ADR, 32'h00000000, "mid reset");
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      finish_test();
   end
endmodule

`default_nettype wire
